// >>> hw/srts_gap_byte_config_pkg.sv
// Register map, field layout and reset values of the SRTS gap/byte configuration block.
// Assumes a 16-bit register view placed in the low half of a 32-bit Avalon-MM word.
package srts_gap_byte_config_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [ADDR_W-1:0] TX_GAP_DIVIDER_IDX = 16'h60B0;
    localparam logic [ADDR_W-1:0] TX_BYTE_COUNT_IDX = 16'h60B2;
    localparam logic [ADDR_W-1:0] RX_GAP_DIVIDER_IDX = 16'h60B4;
    localparam logic [ADDR_W-1:0] RX_BYTE_COUNT_IDX = 16'h60B6;
    localparam int GAP_W = 8;
    localparam int GAP_LSB = 0;
    localparam int CHAN_W = 7;
    localparam int CHAN_LSB = 8;
    localparam int RSVD_BIT = 15;
    localparam int BYTE_W = 9;
    localparam int BYTE_LSB = 0;
    localparam logic [REG_W-1:0] GAP_DIVIDER_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_COUNT_RESET = 9'h177;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : srts_gap_byte_config_pkg

// >>> hw/srts_gap_byte_config.sv
// SRTS transmit/receive gapping divider and byte count registers on Avalon-MM.
// Assumes a word-addressed byte address from the master and one clock domain.
//
// Contract
// RULE1 - Each direction holds an 8-bit spacing between byte-pulse clock pulses.
// RULE2 - Software programs spacing as floor(256/channels) minus one.
// RULE3 - Bits 14:8 of transmit divider hold transmit channel count minus one.
// RULE4 - Bits 14:8 of receive divider hold receive channel count minus one.
// RULE5 - Software never writes channel-count codes 7A to 7F.
// RULE6 - Each direction holds a 9-bit byte count over eight cells.
// RULE7 - Software sets byte count 376 for single-channel pointerless transfer.
// RULE8 - Software sets byte count 375, 374 or 372 for multi-channel transfer.
// RULE9 - Software writes zero to reserved bit 15 of both divider registers.
// RULE10 - Reset loads byte counts with 0177h and dividers with zero.
// RULE11 - Byte count bits 15:9 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module srts_gap_byte_config #(
    parameter int ADDR_W = srts_gap_byte_config_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W+1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [7:0] tx_gap_spacing_o,
    output logic [6:0] tx_circuit_channel_count_o,
    output logic [8:0] tx_byte_count_o,
    output logic [7:0] rx_gap_spacing_o,
    output logic [6:0] rx_circuit_channel_count_o,
    output logic [8:0] rx_byte_count_o
);
    logic [15:0] tx_gap_r;
    logic [15:0] tx_gap_nxt;
    logic [15:0] rx_gap_r;
    logic [15:0] rx_gap_nxt;
    logic [8:0] tx_byte_r;
    logic [8:0] tx_byte_nxt;
    logic [8:0] rx_byte_r;
    logic [8:0] rx_byte_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [ADDR_W-1:0] idx;
    logic req;
    logic [15:0] wmask;

    assign idx = avs_address_i[ADDR_W+1:2];
    assign req = (avs_read_i | avs_write_i) & ~ack_r;
    assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // Access completes one cycle after it is seen: waitrequest drops for exactly that edge
    always_comb begin
        tx_gap_nxt = tx_gap_r;
        rx_gap_nxt = rx_gap_r;
        tx_byte_nxt = tx_byte_r;
        rx_byte_nxt = rx_byte_r;
        rdata_nxt = srts_gap_byte_config_pkg::UNMAPPED_READ;
        ack_nxt = req;
        if (req && avs_write_i) begin
            unique case (idx)
                srts_gap_byte_config_pkg::TX_GAP_DIVIDER_IDX: begin
                    // Reserved bit 15 stays writable, as the hardware keeps it
                    tx_gap_nxt = (tx_gap_r & ~wmask) | (avs_writedata_i[15:0] & wmask); // RULE1 RULE3
                end
                srts_gap_byte_config_pkg::RX_GAP_DIVIDER_IDX: begin
                    rx_gap_nxt = (rx_gap_r & ~wmask) | (avs_writedata_i[15:0] & wmask); // RULE1 RULE4
                end
                srts_gap_byte_config_pkg::TX_BYTE_COUNT_IDX: begin
                    // Only the 9 count bits take data; upper bits ignore writes
                    tx_byte_nxt[7:0] = avs_byteenable_i[0] ? avs_writedata_i[7:0] : tx_byte_r[7:0]; // RULE6
                    tx_byte_nxt[8] = avs_byteenable_i[1] ? avs_writedata_i[8] : tx_byte_r[8]; // RULE11
                end
                srts_gap_byte_config_pkg::RX_BYTE_COUNT_IDX: begin
                    rx_byte_nxt[7:0] = avs_byteenable_i[0] ? avs_writedata_i[7:0] : rx_byte_r[7:0]; // RULE6
                    rx_byte_nxt[8] = avs_byteenable_i[1] ? avs_writedata_i[8] : rx_byte_r[8]; // RULE11
                end
                default: begin
                end
            endcase
        end
        if (req && avs_read_i) begin
            unique case (idx)
                srts_gap_byte_config_pkg::TX_GAP_DIVIDER_IDX: rdata_nxt = {16'h0000, tx_gap_r};
                srts_gap_byte_config_pkg::RX_GAP_DIVIDER_IDX: rdata_nxt = {16'h0000, rx_gap_r};
                srts_gap_byte_config_pkg::TX_BYTE_COUNT_IDX: rdata_nxt = {23'h000000, tx_byte_r}; // RULE11
                srts_gap_byte_config_pkg::RX_BYTE_COUNT_IDX: rdata_nxt = {23'h000000, rx_byte_r}; // RULE11
                default: rdata_nxt = srts_gap_byte_config_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_gap_r <= srts_gap_byte_config_pkg::GAP_DIVIDER_RESET; // RULE10
            rx_gap_r <= srts_gap_byte_config_pkg::GAP_DIVIDER_RESET; // RULE10
            tx_byte_r <= srts_gap_byte_config_pkg::BYTE_COUNT_RESET; // RULE10
            rx_byte_r <= srts_gap_byte_config_pkg::BYTE_COUNT_RESET; // RULE10
            rdata_r <= srts_gap_byte_config_pkg::UNMAPPED_READ;
            ack_r <= 1'b0;
        end else begin
            tx_gap_r <= tx_gap_nxt;
            rx_gap_r <= rx_gap_nxt;
            tx_byte_r <= tx_byte_nxt;
            rx_byte_r <= rx_byte_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // Waitrequest high while idle too; the master only looks at it under a request
    assign avs_waitrequest_o = ~ack_r;
    assign avs_readdata_o = rdata_r;
    // Field outputs are plain slices of the registers, so they still come straight from flops
    assign tx_gap_spacing_o = tx_gap_r[7:0]; // RULE1
    assign tx_circuit_channel_count_o = tx_gap_r[14:8]; // RULE3
    assign rx_gap_spacing_o = rx_gap_r[7:0]; // RULE1
    assign rx_circuit_channel_count_o = rx_gap_r[14:8]; // RULE4
    assign tx_byte_count_o = tx_byte_r; // RULE6
    assign rx_byte_count_o = rx_byte_r; // RULE6
endmodule // srts_gap_byte_config
`default_nettype wire

// >>> dv/srts_gap_byte_config_checker.sv
// Port assertions for the SRTS gap/byte configuration block.
// Assumes one clock, synchronous active-low reset, one wait cycle per access.
`timescale 1ns/1ps
`default_nettype none
module srts_gap_byte_config_checker #(parameter int ADDR_W = 16) (
    input wire logic clk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o,
    input wire logic [ADDR_W+1:0] avs_address_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i, avs_readdata_o,
    input wire logic [7:0] tx_gap_spacing_o, rx_gap_spacing_o,
    input wire logic [6:0] tx_circuit_channel_count_o, rx_circuit_channel_count_o,
    input wire logic [8:0] tx_byte_count_o, rx_byte_count_o
);
    wire logic [15:0] idx = avs_address_i[17:2];
    wire logic take = avs_write_i && avs_waitrequest_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    tx_gap_write_a: assert property (take && idx == 16'h60B0 && avs_byteenable_i[0]
        |=> tx_gap_spacing_o == $past(avs_writedata_i[7:0])) else $error("tx gap not stored");
    tx_chan_write_a: assert property (take && idx == 16'h60B0 && avs_byteenable_i[1]
        |=> tx_circuit_channel_count_o == $past(avs_writedata_i[14:8])) else $error("tx chan");
    rx_chan_write_a: assert property (take && idx == 16'h60B4 && avs_byteenable_i[1]
        |=> rx_circuit_channel_count_o == $past(avs_writedata_i[14:8])) else $error("rx chan");
    rx_bytes_write_a: assert property (take && idx == 16'h60B6 && &avs_byteenable_i[1:0]
        |=> rx_byte_count_o == $past(avs_writedata_i[8:0])) else $error("rx byte count");
    tx_bytes_read_a: assert property (avs_read_i && !avs_waitrequest_o && idx == 16'h60B2
        |-> avs_readdata_o == {23'h000000, tx_byte_count_o}) else $error("byte count read");
    reset_values_a: assert property (disable iff (1'b0) !rst_n_i |=> tx_byte_count_o == 9'h177
        && rx_byte_count_o == 9'h177 && {tx_gap_spacing_o, tx_circuit_channel_count_o,
        rx_gap_spacing_o, rx_circuit_channel_count_o} == 30'h0) else $error("reset values");
endmodule // srts_gap_byte_config_checker
bind srts_gap_byte_config srts_gap_byte_config_checker #(.ADDR_W(ADDR_W)) chk_i (.*);
`default_nettype wire

// >>> dv/srts_gap_byte_config_tb_top.sv
// Self-checking bench for the SRTS gap/byte configuration block.
// Assumes the Avalon-MM slave answers after one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module srts_gap_byte_config_tb_top;
    logic clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
    logic [17:0] avs_address_i = 18'h00000;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic [7:0] tx_gap_spacing_o, rx_gap_spacing_o;
    logic [6:0] tx_circuit_channel_count_o, rx_circuit_channel_count_o;
    logic [8:0] tx_byte_count_o, rx_byte_count_o;
    int errors = 0, num_checks = 0, cyc = 0;
    srts_gap_byte_config dut (.*);
    always #2.5 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] ix, input logic [31:0] d,
        input logic [3:0] be);
        avs_address_i <= {ix, 2'b00};
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_reset();
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk("tx out", 32'({tx_byte_count_o, tx_circuit_channel_count_o, tx_gap_spacing_o}), 32'h00BB8000);
        chk("rx out", 32'({rx_byte_count_o, rx_circuit_channel_count_o, rx_gap_spacing_o}), 32'h00BB8000);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 16'h60B0 + 16'(2 * i), 32'h0, 4'hF);
            chk("reset read", q, i[0] ? 32'h00000177 : 32'h0);
        end
    endtask
    task automatic t_write();
        // Software values: 3 channels gap 84 with 376 bytes (RULE8 wants 375, 374 or 372), 2 channels gap 127, 374 bytes
        logic [15:0] wd [4] = '{16'h0254, 16'hFF78, 16'h017F, 16'h0176};
        logic [15:0] ex [4] = '{16'h0254, 16'h0178, 16'h017F, 16'h0176};
        for (int i = 0; i < 4; i++) bus(1'b1, 16'h60B0 + 16'(2 * i), {16'hFFFF, wd[i]}, 4'hF);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 16'h60B0 + 16'(2 * i), 32'h0, 4'hF);
            chk("readback", q, {16'h0000, ex[i]});
        end
        chk("tx out", 32'({tx_byte_count_o, tx_circuit_channel_count_o, tx_gap_spacing_o}), 32'h00BC0254);
        chk("rx out", 32'({rx_byte_count_o, rx_circuit_channel_count_o, rx_gap_spacing_o}), 32'h00BB017F);
        bus(1'b1, 16'h60B0, 32'h00003A11, 4'h2);
        bus(1'b0, 16'h60B0, 32'h0, 4'hF);
        chk("lane write", q, 32'h00003A54);
    endtask
    task automatic t_unmapped();
        bus(1'b1, 16'h60B8, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 16'h60B8, 32'h0, 4'hF);
        chk("unmapped", q, 32'h0);
        bus(1'b0, 16'h60B2, 32'h0, 4'hF);
        chk("kept", q, 32'h00000178);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard: the whole run needs under a hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        t_reset();
        t_write();
        t_unmapped();
        t_reset();
        complete_run();
    end
endmodule // srts_gap_byte_config_tb_top
`default_nettype wire
